// File: design/cspr_rx.sv
module cspr_rx
    import cspr_pkg::*;
#(
    parameter int HDEPTH = HIST_DEPTH
) (
    // clock, reset, enable
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // serial link from the processor
    input wire logic cpu_status_serial_line,
    // configuration and software control
    input wire logic vretrace_irq_enable,
    input wire logic vretrace_clear,
    // interrupt and status
    output logic mgmt_interrupt_out_n,
    output logic vretrace_status,
    // decoded packet
    output cspr_pkt_t pkt_data,
    output cspr_stat_t pkt_stat,
    // packet history read port
    input wire logic [1:0] hist_addr,
    output logic [7:0] hist_data
);

    initial begin
        if (HDEPTH < 1 || HDEPTH > 4) begin
            $error("cspr_rx: history depth must be 1 to 4");
        end
    end

    // ------------------------------------------------------------
    // receive state machine
    // ------------------------------------------------------------
    cspr_state_t state_r, state_nxt;
    logic [2:0] cnt_r, cnt_nxt;
    logic [7:0] shift_r, shift_nxt;
    logic line_d_r, line_d_nxt;
    logic done_pulse, err_pulse;

    // the line is only ever sampled, there is no drive path
    // one sample per clock is one bit
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        shift_nxt = shift_r;
        line_d_nxt = cpu_status_serial_line;
        done_pulse = 1'b0;
        err_pulse = 1'b0;
        unique case (state_r)
            CSPR_IDLE: begin
                // a rise out of the low interval opens a start
                if (cpu_status_serial_line && !line_d_r) begin
                    state_nxt = CSPR_START;
                end
            end
            CSPR_START: begin
                // second high clock completes the start marker
                if (cpu_status_serial_line) begin
                    state_nxt = CSPR_DATA;
                    cnt_nxt = 3'd0;
                end else begin
                    state_nxt = CSPR_IDLE;
                    err_pulse = 1'b1;
                end
            end
            CSPR_DATA: begin
                // msb arrives first, so shift left
                shift_nxt = {shift_r[6:0], cpu_status_serial_line};
                cnt_nxt = cnt_r + 3'd1;
                if (cnt_r == 3'd7) begin
                    state_nxt = CSPR_END;
                end
            end
            CSPR_END: begin
                // end marker must be high, else the frame is dropped
                if (cpu_status_serial_line) begin
                    done_pulse = 1'b1;
                    state_nxt = CSPR_WAITLOW;
                end else begin
                    err_pulse = 1'b1;
                    state_nxt = CSPR_IDLE;
                end
            end
            CSPR_WAITLOW: begin
                // wait for the return to low before the next start
                if (!cpu_status_serial_line) begin
                    state_nxt = CSPR_IDLE;
                end
            end
            default: begin
                state_nxt = CSPR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state_r <= CSPR_IDLE;
            cnt_r <= 3'd0;
            shift_r <= PKT_RESET;
            line_d_r <= 1'b1;
        end else if (ce) begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            shift_r <= shift_nxt;
            line_d_r <= line_d_nxt;
        end
    end

    // ------------------------------------------------------------
    // packet decode and interrupt
    // ------------------------------------------------------------
    cspr_pkt_t pkt_r, pkt_nxt;
    cspr_stat_t stat_r, stat_nxt;
    logic vr_stat_r, vr_stat_nxt;
    logic [1:0] wptr_r, wptr_nxt;

    // one retrace decode, shared by the set path and the a_clear_drops check
    function automatic logic vr_event(input logic [7:0] pkt,
                                      input logic en);
        return pkt[BIT_VRETRACE] && en;
    endfunction

    // every good frame is latched whole; reserved bits kept as sent
    // bits 7, 6, 1, 0 carry the processor events
    always_comb begin
        pkt_nxt = pkt_r;
        stat_nxt.pkt_valid = done_pulse;
        stat_nxt.frame_error = err_pulse;
        wptr_nxt = wptr_r;
        if (done_pulse) begin
            pkt_nxt = cspr_pkt_t'(shift_r);
            wptr_nxt = (wptr_r == 2'(HDEPTH - 1)) ? 2'd0 : wptr_r + 2'd1;
        end
        // set wins over a clear in the same cycle
        if (done_pulse && vr_event(shift_r, vretrace_irq_enable)) begin
            vr_stat_nxt = 1'b1;
        end else if (vretrace_clear) begin
            vr_stat_nxt = 1'b0;
        end else begin
            vr_stat_nxt = vr_stat_r;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pkt_r <= cspr_pkt_t'(PKT_RESET);
            stat_r <= '0;
            vr_stat_r <= 1'b0;
            wptr_r <= 2'd0;
        end else if (ce) begin
            pkt_r <= pkt_nxt;
            stat_r <= stat_nxt;
            vr_stat_r <= vr_stat_nxt;
            wptr_r <= wptr_nxt;
        end
    end

    // level interrupt follows the sticky cause until cleared
    assign mgmt_interrupt_out_n = ~vr_stat_r;
    assign vretrace_status = vr_stat_r;
    assign pkt_data = pkt_r;
    assign pkt_stat = stat_r;

    // ------------------------------------------------------------
    // history of recent packets, handy for software debug
    // ------------------------------------------------------------
    cspr_hist_mem #(
        .DEPTH(HDEPTH),
        .AW(2)
    ) u_hist (
        .clock(clock),
        .rst(rst),
        .ce(ce),
        .wr_en(done_pulse),
        .wr_addr(wptr_r),
        .wr_data(shift_r),
        .rd_addr(hist_addr),
        .rd_data(hist_data)
    );

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    a_start_two_high: assert property (
        ce && state_r == CSPR_START && cpu_status_serial_line
        |=> state_r == CSPR_DATA && cnt_r == 3'd0)
        else $error("start marker not accepted");

    a_data_eight_bits: assert property (
        ce && state_r == CSPR_DATA && cnt_r == 3'd0 ##1 ce[*7]
        |=> state_r == CSPR_END)
        else $error("data phase not eight bits");

    a_end_marker_done: assert property (
        done_pulse |-> state_r == CSPR_END && cpu_status_serial_line)
        else $error("done without end marker");

    a_pkt_latched: assert property (
        ce && done_pulse |=> pkt_r == $past(shift_r) && stat_r.pkt_valid)
        else $error("packet not latched");

    a_irq_raise: assert property (
        ce && done_pulse && shift_r[7] && vretrace_irq_enable
        |=> !mgmt_interrupt_out_n)
        else $error("retrace interrupt missing");

    a_irq_gated: assert property (
        ce && mgmt_interrupt_out_n && !vretrace_irq_enable
        |=> mgmt_interrupt_out_n)
        else $error("interrupt raised while disabled");

    a_irq_level_hold: assert property (
        !mgmt_interrupt_out_n && !vretrace_clear |=> !mgmt_interrupt_out_n)
        else $error("interrupt dropped before clear");

    a_status_cause: assert property (
        $rose(vretrace_status) |-> $past(ce && done_pulse
            && shift_r[BIT_VRETRACE] && vretrace_irq_enable))
        else $error("status set without retrace cause");

    // framing checks: entry, bit capture and the two ways to drop
    a_rise_opens_start: assert property (
        ce && state_r == CSPR_IDLE && cpu_status_serial_line && !line_d_r
        |=> state_r == CSPR_START)
        else $error("rising line did not open a start");

    a_error_cause: assert property (
        err_pulse |-> !cpu_status_serial_line
            && (state_r == CSPR_START || state_r == CSPR_END))
        else $error("frame error without a low marker");

    a_data_shift: assert property (
        ce && state_r == CSPR_DATA
        |=> shift_r[0] == $past(cpu_status_serial_line))
        else $error("data bit not shifted in");

    // decode outputs: pulse length, hold and history ring
    a_valid_one_cycle: assert property (
        ce && stat_r.pkt_valid |=> !stat_r.pkt_valid)
        else $error("packet valid longer than one cycle");

    a_pkt_kept: assert property (
        ce && !done_pulse |=> $stable(pkt_r))
        else $error("packet changed without a frame");

    a_hist_wrap: assert property (
        ce && done_pulse && wptr_r == 2'(HDEPTH - 1) |=> wptr_r == 2'd0)
        else $error("history pointer did not wrap");

    // clear path and clock enable freeze
    a_clear_drops: assert property (
        ce && vretrace_clear && !(done_pulse
            && vr_event(shift_r, vretrace_irq_enable))
        |=> mgmt_interrupt_out_n)
        else $error("interrupt not released by clear");

    a_ce_freeze: assert property (
        !ce |=> $stable(state_r) && $stable(vr_stat_r) && $stable(pkt_r))
        else $error("state moved while clock enable low");

    c_good_frame: cover property (done_pulse);
    c_bad_frame: cover property (err_pulse);
    c_irq_raised: cover property ($fell(mgmt_interrupt_out_n));
    c_clear_irq: cover property ($rose(mgmt_interrupt_out_n));
    c_ce_hold: cover property (!ce && !mgmt_interrupt_out_n);

endmodule

// File: design/cspr_pkg.sv
package cspr_pkg;

    // ------------------------------------------------------------
    // packet layout
    // ------------------------------------------------------------
    localparam int PKT_BITS = 8;
    localparam int BIT_VRETRACE = 7;
    localparam int BIT_CPU_ACT = 6;
    localparam int BIT_ADDR_DEC = 1;
    localparam int BIT_VID_DEC = 0;

    // ------------------------------------------------------------
    // marker lengths, reset values and history depth
    // ------------------------------------------------------------
    localparam int START_CYCLES = 2;
    localparam int END_CYCLES = 1;
    localparam logic [7:0] PKT_RESET = 8'h00;
    localparam int HIST_DEPTH = 4;

    // ------------------------------------------------------------
    // receiver states
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        CSPR_IDLE = 3'b000,
        CSPR_START = 3'b001,
        CSPR_DATA = 3'b010,
        CSPR_END = 3'b011,
        CSPR_WAITLOW = 3'b100
    } cspr_state_t;

    // decoded packet carried as one struct
    typedef struct packed {
        logic vretrace;
        logic cpu_activity;
        logic [3:0] reserved;
        logic addr_decode;
        logic video_decode;
    } cspr_pkt_t;

    // receive status carried as one struct
    typedef struct packed {
        logic pkt_valid;
        logic frame_error;
    } cspr_stat_t;

endpackage

// File: design/cspr_hist_mem.sv
module cspr_hist_mem
    import cspr_pkg::*;
#(
    parameter int DEPTH = HIST_DEPTH,
    parameter int AW = 2
) (
    // clocking
    input wire logic clock,
    input wire logic rst,
    input wire logic ce,
    // write side
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [7:0] wr_data,
    // read side
    input wire logic [AW-1:0] rd_addr,
    output logic [7:0] rd_data
);

    initial begin
        if (DEPTH > (1 << AW) || DEPTH < 1) begin
            $error("cspr_hist_mem: depth does not fit address width");
        end
    end

    logic [7:0] mem_r [DEPTH];
    logic [7:0] rd_data_nxt;

    // read data comes out of a register
    always_comb begin
        rd_data_nxt = mem_r[rd_addr];
    end

    // storage needs no reset, only the read port does
    always_ff @(posedge clock) begin
        if (ce && wr_en) begin
            mem_r[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rd_data <= PKT_RESET;
        end else if (ce) begin
            rd_data <= rd_data_nxt;
        end
    end

endmodule

// File: test/cspr_tx_model.sv
// ------------------------------------------------------------
// processor side packet sender
// ------------------------------------------------------------
module cspr_tx_model #(
    parameter int GAP = 200
) (
    // clocking
    input wire logic clock,
    input wire logic rst,
    // event sets and a broken end marker on demand
    input wire logic [7:0] ev,
    input wire logic bad_end,
    // link and completion flag
    output logic line,
    output logic sent
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] pkt_r;
    logic [7:0] sh_r;
    int tmr_r;
    int ph_r;
    // one bit per shared clock; this model only ever drives
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            pkt_r <= 8'h00;
            sh_r <= 8'h00;
            tmr_r <= 0;
            ph_r <= 0;
            line <= 1'b0;
            sent <= 1'b0;
        end else begin
            sent <= 1'b0;
            if (ph_r == 0) begin
                line <= 1'b0;
                pkt_r <= pkt_r | ev;
                if (tmr_r < GAP) begin
                    tmr_r <= tmr_r + 1; // 1 us gap
                end else if (pkt_r != 8'h00) begin
                    ph_r <= 1;
                    line <= 1'b1;
                    sh_r <= pkt_r;
                end
            end else begin
                ph_r <= (ph_r == 11) ? 0 : ph_r + 1;
                if (ph_r == 1) line <= 1'b1;
                else if (ph_r < 10) line <= sh_r[9 - ph_r];
                else if (ph_r == 10) line <= !bad_end;
                else line <= 1'b0;
                if (ph_r == 11) begin
                    pkt_r <= 8'h00;
                    tmr_r <= 0;
                    sent <= 1'b1;
                end
            end
        end
    end
endmodule

// File: test/test_cpu_status_serial_packet_rx.sv
// ------------------------------------------------------------
// receiver bench
// ------------------------------------------------------------
module test_cpu_status_serial_packet_rx;
    import cspr_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic [7:0] ev = 8'h00;
    logic bad_end = 1'b0;
    logic irq_en = 1'b0;
    logic clear = 1'b0;
    logic ce = 1'b1;
    logic [1:0] hist_addr = 2'b00;
    logic line, sent, irq_n, status;
    logic [7:0] hist_data;
    logic [7:0] hist_exp [4];
    cspr_pkt_t pkt_data;
    cspr_stat_t pkt_stat;
    logic [9:0] notes [$];
    logic [9:0] nt;
    int mismatches = 0;
    int comparisons = 0;
    int wp = 0;
    logic [7:0] codes [3] = '{8'h40, 8'h02, 8'h01};
    always #2.5 clock = ~clock;
    cspr_tx_model cspr_tx_model_inst (.clock(clock), .rst(rst), .ev(ev),
        .bad_end(bad_end), .line(line), .sent(sent));
    cspr_rx cspr_rx_inst (.clock(clock), .rst(rst), .ce(ce),
        .cpu_status_serial_line(line), .vretrace_irq_enable(irq_en),
        .vretrace_clear(clear), .mgmt_interrupt_out_n(irq_n),
        .vretrace_status(status), .pkt_data(pkt_data), .pkt_stat(pkt_stat),
        .hist_addr(hist_addr), .hist_data(hist_data));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // two event sets per packet, then wait, hold check and clear
    task automatic send(input logic [7:0] a, input logic [7:0] b,
                        input logic en, input logic bad);
        int n;
        logic ex;
        n = 0;
        ex = !((a[7] | b[7]) & en & !bad);
        @(posedge clock);
        irq_en <= en;
        bad_end <= bad;
        ev <= a;
        @(posedge clock);
        ev <= b;
        @(posedge clock);
        ev <= 8'h00;
        notes.push_back({bad, a | b, ex});
        if (!bad) begin
            hist_exp[wp] = a | b;
            wp = (wp + 1) % 4;
        end
        while (sent !== 1'b1 && n < 400) begin
            @(posedge clock);
            n++;
        end
        if (n >= 400) begin
            mismatches++;
            print_verdict();
        end
        @(posedge clock);
        check(irq_n, ex);
        ce <= 1'b0;
        clear <= 1'b1;
        repeat (2) @(posedge clock);
        check(irq_n, ex);
        ce <= 1'b1;
        @(posedge clock);
        clear <= 1'b0;
        @(posedge clock);
        check(irq_n, 1'b1);
        $display("test done %h", a | b);
    endtask
    // result watcher: oldest note against each reported packet
    always @(negedge clock) begin
        if (pkt_stat.pkt_valid === 1'b1 || pkt_stat.frame_error === 1'b1) begin
            if (notes.size() == 0) check(8'h01, 8'h00);
            else begin
                nt = notes.pop_front();
                check(pkt_stat.frame_error, nt[9]);
                if (!nt[9]) begin
                    check(pkt_data, nt[8:1]);
                    check(irq_n, nt[0]);
                    check(status, !nt[0]);
                end
            end
        end
    end
    initial begin
        void'($urandom(32'h2dcb));
        repeat (12) @(posedge clock);
        rst <= 1'b0;
        send(8'h80, 8'h80, 1'b0, 1'b0); // masked retrace
        send(8'h80, 8'h80, 1'b1, 1'b0);
        foreach (codes[i]) send(codes[i], codes[i], 1'b1, 1'b0);
        send(8'h40, 8'h01, 1'b1, 1'b0);
        send(8'h82, 8'h00, 1'b1, 1'b1); // broken end marker
        repeat (2) send(($urandom & 8'hc3) | 8'h02,
                        $urandom & 8'hc3, 1'($urandom), 1'b0);
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            hist_addr <= i[1:0];
            repeat (2) @(posedge clock);
            check(hist_data, hist_exp[i]);
        end
        check(8'(notes.size()), 8'h00);
        print_verdict();
    end
endmodule
